// ===== esob_pkg.sv
`default_nettype none
package esob_pkg;

  // ----------------------------------------------------------------
  // Object addresses (index and sub-index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_DEVICE_KIND = 16'h1000;
  localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_GUARD_INTERVAL = 16'h100C;
  localparam logic [15:0] IDX_LIFE_MULTIPLIER = 16'h100D;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_FIRST_ENTRY = 8'h01;

  // ----------------------------------------------------------------
  // History list geometry and reset values
  // ----------------------------------------------------------------
  localparam int HIST_DEPTH = 17;
  localparam logic [7:0] HIST_DEPTH_U8 = 8'h11;
  localparam logic [7:0] ERR_SUMMARY_RESET = 8'h00;
  localparam logic [15:0] GUARD_RESET = 16'h0000;
  localparam logic [7:0] MULT_RESET = 8'h00;
  localparam logic [7:0] COUNT_CLEAR_VALUE = 8'h00;
  localparam int ERR_BIT = 0;

  // ----------------------------------------------------------------
  // Emergency codes
  // ----------------------------------------------------------------
  localparam logic [15:0] EMCY_NO_ERROR = 16'h0000;
  localparam logic [15:0] EMCY_RX_OVERRUN = 16'h8110;
  localparam logic [15:0] EMCY_GUARD = 16'h8130;
  localparam logic [15:0] EMCY_INPUT_OVERLOAD = 16'hF001;
  localparam logic [15:0] EMCY_LIMIT = 16'hF011;
  localparam logic [15:0] EMCY_DEVICE = 16'hFF00;

  // ----------------------------------------------------------------
  // Description bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] DESC_NONE = 8'h00;
  localparam logic [7:0] DESC_OPEN = 8'h02;
  localparam logic [7:0] DESC_SHORT = 8'h04;
  localparam logic [7:0] DESC_MATH = 8'h08;
  localparam logic [7:0] DESC_LOW_WARN = 8'h10;
  localparam logic [7:0] DESC_HIGH_WARN = 8'h20;
  localparam logic [7:0] DESC_HIGH_SHUT = 8'h40;
  localparam logic [7:0] DESC_FROZEN = 8'h80;
  localparam logic [7:0] DESC_HEARTBEAT = 8'h80;
  localparam logic [7:0] DESC_LIFEGUARD = 8'h10;
  localparam logic [7:0] CHAN_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Fault source layout
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS = 8;
  localparam int NUM_KINDS = 7;
  localparam int NUM_HB = 4;
  localparam int SRC_LIFEGUARD = NUM_INPUTS * NUM_KINDS;
  localparam int SRC_HB_FIRST = SRC_LIFEGUARD + 1;
  localparam int SRC_OVERRUN = SRC_HB_FIRST + NUM_HB;
  localparam int NUM_SRC = SRC_OVERRUN + 1;

  typedef enum logic [2:0] {
    FK_OPEN,
    FK_SHORT,
    FK_LOW_WARN,
    FK_HIGH_WARN,
    FK_HIGH_SHUT,
    FK_MATH,
    FK_FROZEN
  } esob_kind_t;

  // One history entry: description, channel, emergency code
  typedef struct packed {
    logic [7:0] desc;
    logic [7:0] chan;
    logic [15:0] emcy;
  } esob_entry_t;

  // Object access request and answer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } esob_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } esob_rsp_t;

endpackage
`default_nettype wire

// ===== esob_bank.sv
// Behaviour
// - Read-only 32-bit device kind word: extra info high, profile low.
// - Extra-info low byte 0x02 marks analog input blocks; top codes vendor.
// - Error bit 0 set on any error, cleared only when none active.
// - Other error summary bits read zero; value 00h/01h, resets zero.
// - New error enters at entry 1, older shift down; removed on clear.
// - Count sub-index holds listed errors; zero when error-free.
// - Writing zero to count empties the list, even active entries.
// - Emptying list leaves the error bit set while errors are active.
// - At most 17 entries; oldest entries are dropped on overflow.
// - Entry: description byte, channel byte, 16-bit emergency code.
// - Life-guard event records vendor field 0x1000 with code 0x8130.
// - Missed heartbeat records 0x80, producer node, code 0x8130.
// - Open or short input records 0xF001 with description 0x02/0x04.
// - Threshold breach records 0xF011 with 0x10, 0x20 or 0x40.
// - Internal fault records 0xFF00; frozen converter data is 0x80.
// - Sensor and threshold channel byte runs 0x01 to 0x08.
// - Supported codes include 0x0000 no error and 0x8110 overrun.
// - Life time equals guard interval in ms times the multiplier.
// - Zero guard interval or multiplier disables life guarding.
// - Life guarding and heartbeat monitoring never run together.
`timescale 1ns/10ps
`default_nettype none
module esob_bank
  import esob_pkg::*;
#(
  // Arbitrary neutral values, not taken from any real part
  parameter logic [15:0] EXTRA_INFO = 16'h2002,
  parameter logic [15:0] PROFILE_NUM = 16'h0001
)
(
  input wire logic clock,
  input wire logic rst,
  input wire esob_req_t req,
  output esob_rsp_t rsp,
  input wire logic [NUM_INPUTS-1:0][NUM_KINDS-1:0] chan_faults,
  input wire logic lifeguard_event,
  input wire logic [NUM_HB-1:0] hb_missed,
  input wire logic [NUM_HB-1:0][7:0] hb_node_id,
  input wire logic hb_configured,
  input wire logic rx_overrun,
  output logic [7:0] error_summary,
  output logic [7:0] history_count,
  output logic [15:0] last_emcy,
  output logic lifeguard_run,
  output logic heartbeat_run,
  output logic [23:0] life_time_ms
);

  // ----------------------------------------------------------------
  // Entry coding per fault source
  // ----------------------------------------------------------------
  function automatic logic [7:0] kind_desc(input int k);
    unique case (k)
      FK_OPEN: kind_desc = DESC_OPEN;
      FK_SHORT: kind_desc = DESC_SHORT;
      FK_LOW_WARN: kind_desc = DESC_LOW_WARN;
      FK_HIGH_WARN: kind_desc = DESC_HIGH_WARN;
      FK_HIGH_SHUT: kind_desc = DESC_HIGH_SHUT;
      FK_MATH: kind_desc = DESC_MATH;
      default: kind_desc = DESC_FROZEN;
    endcase
  endfunction

  function automatic logic [15:0] kind_emcy(input int k);
    if (k <= FK_SHORT)
      kind_emcy = EMCY_INPUT_OVERLOAD;
    else if (k <= FK_HIGH_SHUT)
      kind_emcy = EMCY_LIMIT;
    else
      kind_emcy = EMCY_DEVICE;
  endfunction

  // Write strobe aimed at sub-index zero of one object; the list clear
  // and both parameter updates share this decode
  function automatic logic obj_wr(input esob_req_t r,
    input logic [15:0] idx);
    obj_wr = r.wr && (r.index == idx) && (r.sub == SUB_ZERO);
  endfunction

  // Builds the 32-bit entry for source s, layout fixed by the struct
  function automatic esob_entry_t src_entry(input int s,
    input logic [NUM_HB-1:0][7:0] nodes);
    esob_entry_t e;
    e = '{desc: DESC_NONE, chan: CHAN_NONE, emcy: EMCY_NO_ERROR};
    if (s < SRC_LIFEGUARD)
    begin
      e.desc = kind_desc(s % NUM_KINDS);
      e.chan = 8'((s / NUM_KINDS) + 1);
      e.emcy = kind_emcy(s % NUM_KINDS);
    end
    else if (s == SRC_LIFEGUARD)
    begin
      e.desc = DESC_LIFEGUARD;
      e.emcy = EMCY_GUARD;
    end
    else if (s < SRC_OVERRUN)
    begin
      e.desc = DESC_HEARTBEAT;
      e.chan = nodes[s - SRC_HB_FIRST];
      e.emcy = EMCY_GUARD;
    end
    else
      e.emcy = EMCY_RX_OVERRUN;
    return e;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  esob_entry_t [HIST_DEPTH-1:0] list_q, list_d;
  logic [7:0] cnt_q, cnt_d;
  logic [NUM_SRC-1:0] seen_q, seen_d;
  logic [15:0] guard_q, guard_d;
  logic [7:0] mult_q, mult_d;
  // Life time held in a flip-flop so the output is registered
  logic [23:0] life_q, life_d;
  logic err_q, err_d;
  logic [15:0] emcy_q, emcy_d;
  esob_rsp_t rsp_q, rsp_d;
  logic [NUM_SRC-1:0] cond;
  logic lg_run;

  // ----------------------------------------------------------------
  // Supervision selection
  // ----------------------------------------------------------------
  // Heartbeat takes precedence: guarding only runs while it is unused
  assign lg_run = (guard_q != GUARD_RESET) && (mult_q != MULT_RESET)
    && !hb_configured;

  // Gather active fault conditions into one source vector. A guard
  // event counts only while guarding runs and a missed heartbeat only
  // while monitoring is set up, so a disabled mechanism never lists
  always_comb
  begin
    cond = '0;
    for (int c = 0; c < NUM_INPUTS; c++)
      for (int k = 0; k < NUM_KINDS; k++)
        cond[c*NUM_KINDS + k] = chan_faults[c][k];
    cond[SRC_LIFEGUARD] = lifeguard_event && lg_run;
    for (int h = 0; h < NUM_HB; h++)
      cond[SRC_HB_FIRST + h] = hb_missed[h] && hb_configured;
    cond[SRC_OVERRUN] = rx_overrun;
  end

  // ----------------------------------------------------------------
  // History list: next state
  // ----------------------------------------------------------------
  // One condition change is handled per cycle, lowest source first;
  // a second change simply waits, since conditions are levels.
  always_comb
  begin
    esob_entry_t e;
    esob_entry_t [HIST_DEPTH-1:0] tmp;
    int j;
    int pick;
    e = '0;
    tmp = '0;
    j = 0;
    pick = -1;
    list_d = list_q;
    cnt_d = cnt_q;
    seen_d = seen_q;
    emcy_d = emcy_q;
    // Manager clear: only an all-zero word empties the list, so a stray
    // nonzero write can never wipe the history
    if (obj_wr(req, IDX_ERROR_HISTORY)
      && req.wdata[7:0] == COUNT_CLEAR_VALUE && req.wdata[31:8] == '0)
    begin
      list_d = '0;
      cnt_d = COUNT_CLEAR_VALUE;
    end
    for (int s = NUM_SRC - 1; s >= 0; s--)
      if (cond[s] != seen_q[s])
        pick = s;
    // Event applied after a clear in the same cycle so it is not lost
    if (pick >= 0)
    begin
      e = src_entry(pick, hb_node_id);
      seen_d[pick] = cond[pick];
      // A rising source enters at the top; on a full list the bottom
      // word falls off, which is how the oldest entries are lost
      if (cond[pick])
      begin
        for (int k = HIST_DEPTH - 1; k > 0; k--)
          list_d[k] = list_d[k-1];
        list_d[0] = e;
        if (cnt_d != HIST_DEPTH_U8)
          cnt_d = cnt_d + 8'h01;
        emcy_d = e.emcy;
      end
      else
      begin
        // A falling source is squeezed out and the words below close
        // up; an entry already cleared by the manager is not found
        for (int k = 0; k < HIST_DEPTH; k++)
          if (8'(k) < cnt_d && list_d[k] != e)
          begin
            tmp[j] = list_d[k];
            j = j + 1;
          end
        list_d = tmp;
        cnt_d = 8'(j);
      end
    end
    err_d = |cond;
    if (err_q && !err_d)
      emcy_d = EMCY_NO_ERROR;
  end

  // ----------------------------------------------------------------
  // Guarding parameters: next state
  // ----------------------------------------------------------------
  // The life time is built from the next values, so it moves on the
  // same edge as the run flag; a one-cycle lag would show a running
  // guard with a life time of zero just after a write.
  always_comb
  begin
    guard_d = guard_q;
    mult_d = mult_q;
    // Upper word bits are ignored, the objects are narrower than it
    if (obj_wr(req, IDX_GUARD_INTERVAL))
      guard_d = req.wdata[15:0];
    if (obj_wr(req, IDX_LIFE_MULTIPLIER))
      mult_d = req.wdata[7:0];
    // Both factors widened first so no product bit is lost
    life_d = {8'h00, guard_d} * {16'h0000, mult_d};
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  // Answer one cycle after the request; unknown objects flag err
  always_comb
  begin
    rsp_d = '0;
    if (req.rd || req.wr)
    begin
      rsp_d.valid = 1'b1;
      rsp_d.err = 1'b1;
      if (req.index == IDX_DEVICE_KIND && req.sub == SUB_ZERO)
      begin
        rsp_d.err = req.wr;
        rsp_d.rdata = {EXTRA_INFO, PROFILE_NUM};
      end
      else if (req.index == IDX_ERROR_SUMMARY && req.sub == SUB_ZERO)
      begin
        rsp_d.err = req.wr;
        rsp_d.rdata = {24'h000000, error_summary};
      end
      else if (req.index == IDX_ERROR_HISTORY && req.sub == SUB_ZERO)
      begin
        rsp_d.err = req.wr && req.wdata != '0;
        rsp_d.rdata = {24'h000000, cnt_q};
      end
      else if (req.index == IDX_ERROR_HISTORY && req.sub >= SUB_FIRST_ENTRY
        && req.sub <= HIST_DEPTH_U8)
      begin
        rsp_d.err = req.wr;
        rsp_d.rdata = list_q[5'(req.sub - SUB_FIRST_ENTRY)];
      end
      else if (req.index == IDX_GUARD_INTERVAL && req.sub == SUB_ZERO)
      begin
        rsp_d.err = 1'b0;
        rsp_d.rdata = {16'h0000, guard_q};
      end
      else if (req.index == IDX_LIFE_MULTIPLIER && req.sub == SUB_ZERO)
      begin
        rsp_d.err = 1'b0;
        rsp_d.rdata = {24'h000000, mult_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // History, error flag and last code; reset leaves the node empty
  // and error-free
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      list_q <= '0;
      cnt_q <= COUNT_CLEAR_VALUE;
      seen_q <= '0;
      err_q <= 1'b0;
      emcy_q <= EMCY_NO_ERROR;
    end
    else
    begin
      list_q <= list_d;
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      err_q <= err_d;
      emcy_q <= emcy_d;
    end
  end

  // Guarding parameters and the life time derived from them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      guard_q <= GUARD_RESET;
      mult_q <= MULT_RESET;
      life_q <= '0;
    end
    else
    begin
      guard_q <= guard_d;
      mult_q <= mult_d;
      life_q <= life_d;
    end
  end

  // Answer register: a lone cycle of valid per request
  always_ff @(posedge clock)
  begin
    if (rst)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

  // Only the generic bit is ever driven
  always_comb
  begin
    error_summary = ERR_SUMMARY_RESET;
    error_summary[ERR_BIT] = err_q;
  end

  // Outputs straight from the registers; the life-guard run flag is decoded
  // from stored parameters and hb_configured; heartbeat_run is hb_configured itself
  assign rsp = rsp_q;
  assign history_count = cnt_q;
  assign life_time_ms = life_q;
  assign last_emcy = emcy_q;
  assign lifeguard_run = lg_run;
  assign heartbeat_run = hb_configured;

endmodule // esob_bank
`default_nettype wire

// ===== esob_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none
module esob_bank_sva
  import esob_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire esob_req_t req,
  input wire esob_rsp_t rsp,
  input wire logic [NUM_INPUTS-1:0][NUM_KINDS-1:0] chan_faults,
  input wire logic lifeguard_event,
  input wire logic [NUM_HB-1:0] hb_missed,
  input wire logic [NUM_HB-1:0][7:0] hb_node_id,
  input wire logic hb_configured,
  input wire logic rx_overrun,
  input wire logic [7:0] error_summary,
  input wire logic [7:0] history_count,
  input wire logic [15:0] last_emcy,
  input wire logic lifeguard_run,
  input wire logic heartbeat_run,
  input wire logic [23:0] life_time_ms
);
  logic any_err;
  logic [5:0] calm_q;
  logic [5:0] calm_d;
  // Any condition that the device must count as an error
  assign any_err = (|chan_faults) | rx_overrun |
    (lifeguard_event & lifeguard_run) | ((|hb_missed) & hb_configured);
  // Quiet cycles, saturating; removals may trail one per cycle
  always_comb calm_d = any_err ? 6'h00 : calm_q + {5'h00, calm_q != 6'h3F};
  always_ff @(posedge clock) calm_q <= rst ? 6'h00 : calm_d;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  a_summary_high: assert property (error_summary[7:1] == 7'h00)
    else $error("error summary upper bits set");
  a_err_set: assert property (any_err [*3] |-> error_summary[0])
    else $error("error bit low while error active");
  a_calm_clear: assert property (calm_q == 6'h3F |->
    error_summary == 8'h00 && history_count == 8'h00)
    else $error("error state left after quiet period");
  a_count_max: assert property (history_count <= 8'h11)
    else $error("history count above limit");
  a_clear_list: assert property (req.wr && req.index == IDX_ERROR_HISTORY
    && req.sub == 8'h00 && req.wdata == 32'h0 |=> history_count <= 8'h01)
    else $error("list not emptied by zero write");
  a_kind_ro: assert property (req.wr && req.index == IDX_DEVICE_KIND
    |=> rsp.valid && rsp.err)
    else $error("write to kind word accepted");
  a_one_super: assert property (!(lifeguard_run && heartbeat_run))
    else $error("both supervision mechanisms running");
  a_lg_zero: assert property (life_time_ms == 24'h0 |-> !lifeguard_run)
    else $error("life guarding running with zero time");
  a_free_emcy: assert property ($fell(error_summary[0]) |->
    ##[0:2] last_emcy == 16'h0000)
    else $error("no error reset code after recovery");
endmodule // esob_bank_sva
bind esob_bank esob_bank_sva esob_bank_sva_i (.clock, .rst, .req, .rsp,
  .chan_faults, .lifeguard_event, .hb_missed, .hb_node_id, .hb_configured,
  .rx_overrun, .error_summary, .history_count, .last_emcy, .lifeguard_run,
  .heartbeat_run, .life_time_ms);
`default_nettype wire

// ===== esob_mgr_model.sv
`timescale 1ns/10ps
`default_nettype none
module esob_mgr_model
  import esob_pkg::*;
(
  input wire logic clock,
  input wire esob_rsp_t rsp,
  output var esob_req_t req
);
  // Bus idles with strobes low
  initial req = '0;
  // One access: held to the taking edge, then fields inverted so a stale
  // value is never mistaken for a live one
  task automatic access(input logic w, input logic [15:0] ix,
    input logic [7:0] sb, input logic [31:0] wd, output esob_rsp_t r);
    @(posedge clock);
    #1;
    req = '{rd: !w, wr: w, index: ix, sub: sb, wdata: wd};
    @(posedge clock);
    #1;
    r = rsp;
    req = '{rd: 1'b0, wr: 1'b0, index: ~ix, sub: ~sb, wdata: ~wd};
  endtask
endmodule // esob_mgr_model
`default_nettype wire

// ===== esob_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module esob_bank_tb_top;
  import esob_pkg::*;
  // Arbitrary neutral identity halves
  localparam logic [15:0] XI = 16'h3002;
  localparam logic [15:0] PN = 16'h0007;
  logic clock;
  logic rst;
  esob_req_t req;
  esob_rsp_t rsp;
  esob_rsp_t r;
  logic [55:0] flt;
  logic lg_ev;
  logic [3:0] hb_miss;
  logic [3:0][7:0] hb_id;
  logic hb_cfg;
  logic ovr;
  logic [7:0] err_sum;
  logic [7:0] cnt;
  logic [15:0] emcy;
  logic lg_run;
  logic hb_run;
  logic [23:0] life;
  logic [15:0] g;
  logic [7:0] m;
  int c;
  int n_fail;
  int total_checks;
  esob_bank #(.EXTRA_INFO(XI), .PROFILE_NUM(PN)) esob_bank_i (.clock, .rst,
    .req, .rsp, .chan_faults(flt), .lifeguard_event(lg_ev),
    .hb_missed(hb_miss), .hb_node_id(hb_id), .hb_configured(hb_cfg),
    .rx_overrun(ovr), .error_summary(err_sum), .history_count(cnt),
    .last_emcy(emcy), .lifeguard_run(lg_run), .heartbeat_run(hb_run),
    .life_time_ms(life));
  esob_mgr_model esob_mgr_model_i (.clock, .rsp, .req);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb);
    esob_mgr_model_i.access(1'b0, ix, sb, 32'h0, r);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] sb,
    input logic [31:0] wd);
    esob_mgr_model_i.access(1'b1, ix, sb, wd, r);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Entry for input fault source i = input*7 + kind
  function automatic logic [31:0] ent(input int i);
    logic [6:0][7:0] d;
    d = {8'h80, DESC_MATH, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02};
    return {d[i % 7], 8'(i / 7 + 1),
      (i % 7 < 2) ? 16'hF001 : (i % 7 < 5) ? 16'hF011 : 16'hFF00};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog; the full sequence needs well under a tenth of this
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    void'($urandom(18));
    rst = 1'b1;
    flt = '0;
    {lg_ev, hb_miss, hb_cfg, ovr} = '0;
    hb_id = $urandom();
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    rd(IDX_DEVICE_KIND, SUB_ZERO);
    chk("kind", r.rdata, {XI, PN});
    chk("valid", r.valid, 1'b1);
    chk("blocks", r.rdata[23:16], 8'h02);
    rd(IDX_ERROR_SUMMARY, SUB_ZERO);
    chk("summary", r.rdata, 32'h0);
    rd(IDX_LIFE_MULTIPLIER, SUB_ZERO);
    chk("mult rst", r.rdata, 32'h0);
    wr(IDX_DEVICE_KIND, SUB_ZERO, 32'h0);
    chk("ro", r.err, 1'b1);
    wr(IDX_ERROR_HISTORY, SUB_ZERO, 32'h5);
    chk("cnt wr", r.err, 1'b1);
    // Guard parameters: zero and full-scale corners, then random
    for (int i = 0; i < 6; i++)
    begin
      g = (i == 0) ? 16'h0 : (i < 3) ? 16'hFFFF : 16'($urandom_range(65535, 1));
      m = (i == 1) ? 8'h0 : (i < 3) ? 8'hFF : 8'($urandom_range(255, 1));
      wr(IDX_GUARD_INTERVAL, SUB_ZERO, {16'h0, g});
      wr(IDX_LIFE_MULTIPLIER, SUB_ZERO, {24'h0, m});
      rd(IDX_GUARD_INTERVAL, SUB_ZERO);
      chk("guard", r.rdata, {16'h0, g});
      chk("life", life, g * m);
      chk("lg run", lg_run, g != 0 && m != 0);
    end
    hb_cfg = 1'b1;
    tick(1);
    chk("exclusive", lg_run, 1'b0);
    chk("hb run", hb_run, 1'b1);
    hb_cfg = 1'b0;
    // Every fault kind on a random input, listed then removed
    for (int k = 0; k < 7; k++)
    begin
      c = $urandom_range(7) * 7 + k;
      flt[c] = 1'b1;
      tick(2);
      rd(IDX_ERROR_HISTORY, SUB_FIRST_ENTRY);
      chk("entry", r.rdata, ent(c));
      chk("count", cnt, 1);
      chk("sum set", err_sum, 8'h01);
      flt[c] = 1'b0;
      tick(2);
      chk("count 0", cnt, 0);
      chk("emcy 0", emcy, 16'h0000);
    end
    // Eighteen faults: newest on top, oldest lost
    for (int i = 0; i < 18; i++)
    begin
      flt[i] = 1'b1;
      tick(2);
    end
    chk("full", cnt, 17);
    rd(IDX_ERROR_HISTORY, SUB_FIRST_ENTRY);
    chk("newest", r.rdata, ent(17));
    rd(IDX_ERROR_HISTORY, 8'h11);
    chk("oldest", r.rdata, ent(1));
    rd(IDX_ERROR_HISTORY, 8'h12);
    chk("beyond", r.err, 1'b1);
    wr(IDX_ERROR_HISTORY, SUB_ZERO, 32'h0);
    chk("emptied", cnt, 0);
    chk("still err", err_sum, 8'h01);
    flt = '0;
    tick(70);
    chk("idle", err_sum, 8'h00);
    // Supervision events and receive overrun
    lg_ev = 1'b1;
    tick(2);
    rd(IDX_ERROR_HISTORY, SUB_FIRST_ENTRY);
    chk("lifeguard", r.rdata, 32'h10008130);
    lg_ev = 1'b0;
    wr(IDX_GUARD_INTERVAL, SUB_ZERO, 32'h0);
    hb_cfg = 1'b1;
    c = $urandom_range(3);
    hb_miss[c] = 1'b1;
    tick(2);
    rd(IDX_ERROR_HISTORY, SUB_FIRST_ENTRY);
    chk("heartbeat", r.rdata, {8'h80, hb_id[c], 16'h8130});
    hb_miss = '0;
    ovr = 1'b1;
    tick(2);
    chk("ovr emcy", emcy, 16'h8110);
    ovr = 1'b0;
    tick(4);
    wrap_up();
  end
endmodule // esob_bank_tb_top
`default_nettype wire
